//--- inc/hsp_pkg.sv
// Package: constants and carrier types for the host serial port
package hsp_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned BAUD_MIN = 1200;
  localparam int unsigned BAUD_MAX = 115200;
  localparam int unsigned BAUD_DEF = 115200;
  localparam int unsigned DIV_W = 17;
  localparam int unsigned DIV_DEF = CLK_HZ / BAUD_DEF;
  localparam int unsigned DIV_MAX = CLK_HZ / BAUD_MIN;
  localparam int unsigned NUM_GPIO = 7;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic START_LVL = 1'b0;
  localparam logic STOP_LVL = 1'b1;
  localparam logic [3:0] BITS_7 = 4'h7;
  localparam logic [3:0] BITS_8 = 4'h8;

  // Character format
  typedef struct packed {
    logic eight_bits;
    logic parity_en;
    logic parity_odd;
  } frame_cfg_t;

  // Radio events from the modem core
  typedef struct packed {
    logic tx_active;
    logic sync_found;
    logic rx_done;
  } radio_evt_t;
endpackage : hsp_pkg

//--- rtl/uart_tx_lane.sv
// Serial character transmitter
`timescale 1ns/1ns
module uart_tx_lane #(
  parameter int unsigned DIV_W = hsp_pkg::DIV_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Setup
  input wire logic [DIV_W-1:0] bit_div,
  input wire hsp_pkg::frame_cfg_t cfg,
  input wire logic cts_ok,
  // Byte stream
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  // Line
  output logic txd
);
  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_SHIFT = 2'b01
  } tx_state_t;

  tx_state_t state;
  logic [10:0] shreg;
  logic [3:0] left;
  logic [DIV_W-1:0] cnt;
  wire logic par_bit;
  wire logic [3:0] nbits;
  wire logic bit_end;
  wire logic start_ok;

  assign nbits = cfg.eight_bits ? hsp_pkg::BITS_8 : hsp_pkg::BITS_7;
  assign par_bit = (cfg.eight_bits ? ^tx_data : ^tx_data[6:0]) ^
                   cfg.parity_odd;
  assign bit_end = (cnt == bit_div - 1'b1);
  assign start_ok = (state == T_IDLE) && cts_ok;
  assign tx_ready = start_ok;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= T_IDLE;
      shreg <= 11'h7ff;
      left <= 4'h0;
      cnt <= '0;
      txd <= hsp_pkg::LINE_IDLE;
    end else if (clk_en) begin
      case (state)
        T_IDLE: begin
          txd <= hsp_pkg::LINE_IDLE;
          cnt <= '0;
          if (tx_valid && start_ok) begin
            txd <= hsp_pkg::START_LVL;
            if (cfg.eight_bits)
              shreg <= {hsp_pkg::STOP_LVL, cfg.parity_en ? par_bit :
                        hsp_pkg::STOP_LVL, tx_data, 1'b0};
            else
              shreg <= {hsp_pkg::STOP_LVL, hsp_pkg::STOP_LVL,
                        cfg.parity_en ? par_bit : hsp_pkg::STOP_LVL,
                        tx_data[6:0], 1'b0};
            left <= nbits + {3'h0, cfg.parity_en} + 4'h1;
            state <= T_SHIFT;
          end
        end
        T_SHIFT: begin
          if (bit_end) begin
            cnt <= '0;
            shreg <= {1'b1, shreg[10:1]};
            txd <= shreg[1];
            if (left == 4'h0)
              state <= T_IDLE;
            else
              left <= left - 4'h1;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        default: state <= T_IDLE;
      endcase
    end
  end

  property p_tx_cts;
    @(posedge ref_clk) disable iff (!nrst)
    (clk_en && !cts_ok && state == T_IDLE) |=> (state == T_IDLE && txd);
  endproperty
  a_tx_cts: assert property (p_tx_cts)
    else $error("tx started with cts high");

  property p_idle_line;
    @(posedge ref_clk) disable iff (!nrst)
    (state == T_IDLE && $past(state) == T_IDLE && $past(clk_en)) |-> txd;
  endproperty
  a_idle_line: assert property (p_idle_line)
    else $error("txd low at idle");
endmodule : uart_tx_lane

//--- rtl/host_serial_port.sv
// Host serial port of the radio module: uart, flow control, status pins
`timescale 1ns/1ns
// Contract
// - A low level on the reset input resets all logic, high runs.
// - Serial data is NRZ and a one bit is a high level on the line.
// - Characters go out toward the user only while clear to send is low; the code checks cts_n only when a character starts.
// - Request to send is low when receive can take a byte, else high.
// - A wake request takes the module out of low power mode.
// - Radio status rises during transmission and on a good sync word.
// - Radio status falls at end of transmission or of frame reception.
// - Standby status is one while operating and zero during standby.
// - Each general I/O pin is configurable as input or output.
// - Full duplex link, 1200 to 115200 bit/s, 7 or 8 bits, parity.
// - Wake request is active high and idles low.
module host_serial_port #(
  parameter int unsigned DIV_W = hsp_pkg::DIV_W,
  parameter int unsigned NUM_GPIO = hsp_pkg::NUM_GPIO
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Setup from the core
  input wire logic [DIV_W-1:0] bit_div,
  input wire hsp_pkg::frame_cfg_t cfg,
  // Transmit stream toward user
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  // Receive stream from user
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  output logic rx_parity_err,
  output logic rx_frame_err,
  // Serial pins
  output logic txd,
  input wire logic rxd,
  input wire logic cts_n,
  output logic rts_n,
  // Power control
  input wire logic wake_request_in,
  input wire logic sleep_req,
  output logic awake,
  output logic standby_status,
  // Radio
  input wire hsp_pkg::radio_evt_t radio_evt,
  output logic radio_status,
  // General I/O
  input wire logic [NUM_GPIO-1:0] gpio_dir_out,
  input wire logic [NUM_GPIO-1:0] gpio_out_val,
  output logic [NUM_GPIO-1:0] gpio_in_val,
  input wire logic [NUM_GPIO-1:0] gpio_i,
  output logic [NUM_GPIO-1:0] gpio_o,
  output logic [NUM_GPIO-1:0] gpio_oe
);
  typedef enum logic [1:0] {
    R_IDLE = 2'b00,
    R_SHIFT = 2'b01,
    R_STOP = 2'b10
  } rx_state_t;

  function automatic logic parity_of(input logic [7:0] d,
                                     input hsp_pkg::frame_cfg_t c);
    parity_of = (c.eight_bits ? ^d : ^d[6:0]) ^ c.parity_odd;
  endfunction : parity_of

  rx_state_t state;
  logic [3:0] left;
  logic [DIV_W-1:0] cnt;
  logic [7:0] shreg;
  logic par_seen;
  logic in_par;
  wire logic half_pt;
  wire logic bit_end;
  wire logic [3:0] nbits;
  wire logic hold_full;
  wire logic [7:0] rx_aligned;
  logic rx_frame;
  wire logic frame_on;

  uart_tx_lane #(.DIV_W(DIV_W)) u_tx (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .bit_div(bit_div),
    .cfg(cfg),
    .cts_ok(~cts_n),
    .tx_valid(tx_valid && awake),
    .tx_ready(tx_ready),
    .tx_data(tx_data),
    .txd(txd)
  );

  assign nbits = cfg.eight_bits ? hsp_pkg::BITS_8 : hsp_pkg::BITS_7;
  assign half_pt = (cnt == {1'b0, bit_div[DIV_W-1:1]});
  assign bit_end = (cnt == bit_div - 1'b1);
  assign hold_full = rx_valid && !rx_ready;
  assign rx_aligned = cfg.eight_bits ? shreg : {1'b0, shreg[7:1]};

  // Receiver, sampling mid bit
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= R_IDLE;
      left <= 4'h0;
      cnt <= '0;
      shreg <= 8'h00;
      par_seen <= 1'b0;
      in_par <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      rx_parity_err <= 1'b0;
      rx_frame_err <= 1'b0;
    end else if (clk_en) begin
      if (rx_valid && rx_ready)
        rx_valid <= 1'b0;
      case (state)
        R_IDLE: begin
          cnt <= '0;
          if (rxd == hsp_pkg::START_LVL)
            state <= R_SHIFT;
          left <= nbits + {3'h0, cfg.parity_en};
          in_par <= 1'b0;
        end
        R_SHIFT: begin
          cnt <= bit_end ? '0 : cnt + 1'b1;
          if (half_pt) begin
            if (left == nbits + {3'h0, cfg.parity_en} && !in_par &&
                rxd != hsp_pkg::START_LVL) begin
              state <= R_IDLE;
            end else if (!in_par) begin
              in_par <= 1'b1;
            end else begin
              if (cfg.parity_en && left == 4'h1)
                par_seen <= rxd;
              else
                shreg <= {rxd, shreg[7:1]};
              left <= left - 4'h1;
              if (left == 4'h1)
                state <= R_STOP;
            end
          end
        end
        R_STOP: begin
          cnt <= bit_end ? '0 : cnt + 1'b1;
          if (half_pt) begin
            state <= R_IDLE;
            rx_valid <= 1'b1;
            rx_data <= rx_aligned;
            rx_frame_err <= (rxd != hsp_pkg::STOP_LVL);
            rx_parity_err <= cfg.parity_en &&
                             (parity_of(rx_aligned, cfg) != par_seen);
          end
        end
        default: state <= R_IDLE;
      endcase
    end
  end

  // refuse while holding byte or asleep
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      rts_n <= 1'b1;
    else if (clk_en)
      rts_n <= hold_full || !awake;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      awake <= 1'b1;
    else if (clk_en) begin
      if (wake_request_in)
        awake <= 1'b1;
      else if (sleep_req)
        awake <= 1'b0;
    end
  end

  assign standby_status = awake;

  // frame held from sync to end
  assign frame_on = radio_evt.sync_found || (rx_frame && !radio_evt.rx_done);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_frame <= 1'b0;
      radio_status <= 1'b0;
    end else if (clk_en) begin
      rx_frame <= frame_on;
      radio_status <= radio_evt.tx_active || frame_on;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gpio_o <= '0;
      gpio_oe <= '0;
      gpio_in_val <= '0;
    end else if (clk_en) begin
      gpio_o <= gpio_out_val;
      gpio_oe <= gpio_dir_out;
      gpio_in_val <= gpio_i;
    end
  end

  property p_rts_hold;
    @(posedge ref_clk) disable iff (!nrst)
    (clk_en && hold_full) |=> rts_n;
  endproperty
  a_rts_hold: assert property (p_rts_hold)
    else $error("rts low while full");

  property p_wake;
    @(posedge ref_clk) disable iff (!nrst)
    (clk_en && wake_request_in) |=> standby_status;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake ignored");

  property p_radio_up;
    @(posedge ref_clk) disable iff (!nrst)
    (clk_en && radio_evt.sync_found) |=> radio_status;
  endproperty
  a_radio_up: assert property (p_radio_up)
    else $error("radio status low");

  property p_radio_dn;
    @(posedge ref_clk) disable iff (!nrst)
    (clk_en && radio_evt.rx_done && !radio_evt.tx_active &&
     !radio_evt.sync_found) |=> !radio_status;
  endproperty
  a_radio_dn: assert property (p_radio_dn)
    else $error("radio status high");

  property p_standby;
    @(posedge ref_clk) disable iff (!nrst)
    (clk_en && sleep_req && !wake_request_in) |=> !standby_status;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby not shown");

  property p_gpio;
    @(posedge ref_clk) disable iff (!nrst)
    clk_en |=> (gpio_oe == $past(gpio_dir_out));
  endproperty
  a_gpio: assert property (p_gpio)
    else $error("gpio dir wrong");
endmodule : host_serial_port

//--- tb/host_model.sv
// Host side model: sends and captures serial characters
`timescale 1ns/1ns
module host_model #(
  parameter int BD = 8
) (
  // Clock
  input wire logic ref_clk,
  // Serial pins
  input wire logic txd,
  output logic rxd,
  output logic cts_n,
  input wire logic rts_n
);
  initial begin
    rxd = 1'b1;
    cts_n = 1'b1;
  end
  // grant or withhold clear to send
  task automatic clear_to_send(input logic v);
    cts_n = v;
  endtask : clear_to_send
  // send n bits from start bit, once rts_n is low
  task automatic send(input logic [10:0] frm, input int n);
    int i;
    while (rts_n !== 1'b0) @(posedge ref_clk);
    for (i = 0; i < n; i++) begin
      rxd <= frm[i];
      repeat (BD) @(posedge ref_clk);
    end
  endtask : send
  // capture n bits after the start bit, lsb first
  task automatic get(output logic [10:0] frm, input int n);
    int i;
    frm = '1;
    while (txd !== 1'b0) @(posedge ref_clk);
    repeat (BD / 2) @(posedge ref_clk);
    for (i = 0; i < n; i++) begin
      repeat (BD) @(posedge ref_clk);
      frm[i] = txd;
    end
  endtask : get
endmodule : host_model

//--- tb/host_serial_port_tb.sv
// Testbench for the host serial port
`timescale 1ns/1ns
module host_serial_port_tb;
  localparam int BD = 8;
  typedef struct packed {
    logic [2:0] evt;
    logic slp;
    logic wk;
    logic [6:0] dir;
    logic [6:0] ov;
    logic [6:0] gi;
    logic rs;
    logic sb;
  } row_t;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic rx_ready = 1'b0;
  logic wake_request_in = 1'b0;
  logic sleep_req = 1'b0;
  hsp_pkg::radio_evt_t radio_evt = '0;
  logic [6:0] gpio_dir_out = 7'h00;
  logic [6:0] gpio_out_val = 7'h00;
  logic [6:0] gpio_i = 7'h00;
  logic tx_ready, rx_valid, rx_parity_err, rx_frame_err;
  logic txd, rxd, cts_n, rts_n, awake, standby_status, radio_status;
  logic [7:0] rx_data;
  logic [10:0] got;
  hsp_pkg::frame_cfg_t cfg = '{1'b1, 1'b0, 1'b0};
  logic [6:0] gpio_in_val, gpio_o, gpio_oe;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int k;
  row_t rows [8] = '{
    '{3'h4, 1'b0, 1'b0, 7'h55, 7'h0f, 7'h2a, 1'b1, 1'b1},
    '{3'h0, 1'b0, 1'b0, 7'h2a, 7'h7f, 7'h55, 1'b0, 1'b1},
    '{3'h2, 1'b0, 1'b0, 7'h7f, 7'h33, 7'h00, 1'b1, 1'b1},
    '{3'h0, 1'b0, 1'b0, 7'h7f, 7'h33, 7'h00, 1'b1, 1'b1},
    '{3'h1, 1'b0, 1'b0, 7'h00, 7'h00, 7'h7f, 1'b0, 1'b1},
    '{3'h0, 1'b1, 1'b0, 7'h01, 7'h01, 7'h40, 1'b0, 1'b0},
    '{3'h0, 1'b1, 1'b1, 7'h40, 7'h40, 7'h01, 1'b0, 1'b1},
    '{3'h0, 1'b0, 1'b0, 7'h00, 7'h00, 7'h00, 1'b0, 1'b1}};
  always #4 ref_clk = ~ref_clk;
  host_serial_port i_dut (.ref_clk(ref_clk), .nrst(nrst), .clk_en(1'b1),
    .bit_div(17'h00008), .cfg(cfg), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .rx_parity_err(rx_parity_err),
    .rx_frame_err(rx_frame_err), .txd(txd), .rxd(rxd), .cts_n(cts_n),
    .rts_n(rts_n), .wake_request_in(wake_request_in),
    .sleep_req(sleep_req), .awake(awake),
    .standby_status(standby_status), .radio_evt(radio_evt),
    .radio_status(radio_status), .gpio_dir_out(gpio_dir_out),
    .gpio_out_val(gpio_out_val), .gpio_in_val(gpio_in_val),
    .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe));
  host_model #(.BD(BD)) i_host (.ref_clk(ref_clk), .txd(txd), .rxd(rxd),
    .cts_n(cts_n), .rts_n(rts_n));
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_sim;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic tx_case(input logic [7:0] d, input int n);
    int w;
    tx_valid = 1'b1;
    tx_data = d;
    fork
      i_host.get(got, n);
      begin
        w = 0;
        while (tx_ready !== 1'b1 && w < 50) begin
          @(negedge ref_clk);
          w++;
        end
        @(negedge ref_clk);
        tx_valid = 1'b0;
      end
    join
    @(negedge ref_clk);
  endtask : tx_case
  task automatic rx_case(input logic [10:0] frm, input int n,
                         input logic [7:0] ed, input logic ep);
    int w;
    w = 0;
    fork
      i_host.send(frm, n);
      while (rx_valid !== 1'b1 && w < 400) begin
        @(negedge ref_clk);
        w++;
      end
    join
    repeat (2) @(negedge ref_clk);
    chk("rx_valid", 8'h01, {7'h00, rx_valid});
    chk("rx_char", ed, rx_data);
    chk("rx_perr", {7'h00, ep}, {7'h00, rx_parity_err});
    chk("rx_ferr", 8'h00, {7'h00, rx_frame_err});
    chk("rts_n", 8'h01, {7'h00, rts_n});
    rx_ready = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("rx_valid", 8'h00, {7'h00, rx_valid});
    chk("rts_n", 8'h00, {7'h00, rts_n});
    rx_ready = 1'b0;
  endtask : rx_case
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    repeat (2) @(negedge ref_clk);
    chk("txd", 8'h01, {7'h00, txd});
    chk("rts_n", 8'h01, {7'h00, rts_n});
    chk("radio", 8'h00, {7'h00, radio_status});
    chk("oe", 8'h00, {1'b0, gpio_oe});
    nrst = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("rts_n", 8'h00, {7'h00, rts_n});
    $display("test reset done");
    for (k = 0; k < 8; k++) begin
      {radio_evt, sleep_req, wake_request_in} =
          {rows[k].evt, rows[k].slp, rows[k].wk};
      {gpio_dir_out, gpio_out_val, gpio_i} = rows[k][22:2];
      repeat (2) @(negedge ref_clk);
      chk("radio", {7'h00, rows[k].rs}, {7'h00, radio_status});
      chk("standby", {7'h00, rows[k].sb}, {7'h00, standby_status});
      chk("awake", {7'h00, rows[k].sb}, {7'h00, awake});
      chk("oe", {1'b0, gpio_dir_out}, {1'b0, gpio_oe});
      chk("o", {1'b0, gpio_out_val & gpio_dir_out},
          {1'b0, gpio_o & gpio_dir_out});
      chk("in", {1'b0, gpio_i & ~gpio_dir_out},
          {1'b0, gpio_in_val & ~gpio_dir_out});
    end
    $display("test rows done");
    tx_valid = 1'b1;
    tx_data = 8'ha5;
    repeat (4) @(negedge ref_clk);
    chk("tx_ready", 8'h00, {7'h00, tx_ready});
    chk("txd", 8'h01, {7'h00, txd});
    i_host.clear_to_send(1'b0);
    tx_case(8'ha5, 9);
    chk("tx_char", 8'ha5, got[7:0]);
    chk("tx_stop", 8'h01, {7'h00, got[8]});
    cfg = '{1'b0, 1'b1, 1'b1};
    tx_case(8'hb5, 9);
    chk("tx7_char", 8'h35, {1'b0, got[6:0]});
    chk("tx7_par", 8'h01, {7'h00, got[7]});
    chk("tx7_stop", 8'h01, {7'h00, got[8]});
    $display("test transmit done");
    cfg = '{1'b1, 1'b0, 1'b0};
    rx_case({2'b11, 8'h3c, 1'b0}, 10, 8'h3c, 1'b0);
    cfg = '{1'b0, 1'b1, 1'b1};
    rx_case({2'b11, 1'b1, 7'h35, 1'b0}, 10, 8'h35, 1'b0);
    rx_case({2'b11, 1'b0, 7'h35, 1'b0}, 10, 8'h35, 1'b1);
    $display("test receive done");
    nrst = 1'b0;
    #1;
    chk("txd", 8'h01, {7'h00, txd});
    chk("rx_valid", 8'h00, {7'h00, rx_valid});
    chk("rts_n", 8'h01, {7'h00, rts_n});
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("rts_n", 8'h00, {7'h00, rts_n});
    chk("txd", 8'h01, {7'h00, txd});
    $display("test second reset done");
    end_sim();
  end
endmodule : host_serial_port_tb
